// ### logic/second_down_timer.sv
// Six-bit down counter with stop-on-underflow and optional reload
`timescale 1ns/1ps
`default_nettype none
module second_down_timer (
	input wire logic clock, // Core clock
	input wire logic resetn, // Asynchronous reset, active low
	timer_ctrl_if.timer tif // Control from the status block
);

	typedef struct packed {
		logic [5:0] count;
		logic [5:0] init;
		logic running;
		logic underflow;
	} timer_state_t;

	timer_state_t state_reg;
	timer_state_t state_next;

	always_comb begin
		state_next = state_reg;
		state_next.underflow = 1'b0;
		if (tif.load) begin
			state_next.init = tif.init;
			state_next.count = tif.init;
			state_next.running = 1'b1;
		end else if (tif.tick && state_reg.running) begin
			if (state_reg.count == timer_wake_pkg::CNT_ZERO) begin
				state_next.underflow = 1'b1;
				if (tif.reload_en) begin
					// Reload keeps counting so long periods chain without a gap
					state_next.count = state_reg.init;
				end else begin
					state_next.count = timer_wake_pkg::CNT_MAX;
					state_next.running = 1'b0;
				end
			end else begin
				state_next.count = state_reg.count - 6'h01;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign tif.underflow = state_reg.underflow;
	assign tif.running = state_reg.running;
	assign tif.count = state_reg.count;

endmodule
`default_nettype wire

// ### logic/timer_ctrl_if.sv
// Control and status carrier between the wake status block and its down counter
`timescale 1ns/1ps
`default_nettype none
interface timer_ctrl_if;
	logic load;
	logic [5:0] init;
	logic tick;
	logic reload_en;
	logic underflow;
	logic running;
	logic [5:0] count;

	modport ctrl (
		output load,
		output init,
		output tick,
		output reload_en,
		input underflow,
		input running,
		input count
	);

	modport timer (
		input load,
		input init,
		input tick,
		input reload_en,
		output underflow,
		output running,
		output count
	);
endinterface
`default_nettype wire

// ### logic/timer_reload_wake_status.sv
// Reload timer, converter count gate and wake status registers
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Six-bit down counter, load starts, underflow requests wake
// - Flag group two bit 0 enables reload
// - Timer opens count gate, underflow closes it
// - Defer flag keeps gate open across underflow
// - Reload with defer keeps counting through underflows
// - Status registers four bits, unused bits zero
// - Carry bit 3 read/write, zero bit 2
// - Zero flag tracks accumulator equal to zero
// - Arithmetic status read out, only its carry loaded from RAM
// - Summary flag at bit 2, read only
// - Summary set by non-port release or timed start flags, not by port start
// - Any start flag refuses halt entry
// - Prescaler start flag is request and enable
// - Live fifteenth prescaler stage at bit 2
// - Port start set by change, cleared by select
// - Timer start flag is request and enable
// - Converter start flag is finish and enable
// - Source status read only, bit 0 unused
// - Overflow flag set by overflow, cleared by start
// - Overflow status at bit 2, read only
// - Timer wake enable lets underflow release halt
module timer_reload_wake_status (
	input wire logic clock, // 40 MHz core clock
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic cmd_valid, // One-cycle instruction strobe
	input wire timer_wake_pkg::cmd_op_t cmd_op, // Instruction being executed
	input wire logic [8:0] cmd_arg, // Instruction operand
	input wire logic [3:0] ram_nibble, // RAM data for the status load
	input wire logic [3:0] acc_nibble, // Live accumulator content
	input wire logic carry_update, // ALU writes the carry this cycle
	input wire logic carry_value, // ALU carry or borrow result
	input wire logic [15:1] prescale_stage, // Prescaler stage outputs
	input wire logic freq_level, // Converter frequency clock level
	input wire logic prescale_overflow, // Prescaler overflow pulse
	input wire logic port_change_release, // Selected port change released halt
	input wire logic other_halt_release, // Non-port source released halt
	input wire logic rfc_finish, // Converter mode-3 finish pulse
	input wire logic rfc_counter_overflow, // 16-bit converter counter overflow
	output logic [3:0] read_nibble, // Status value for accumulator and RAM
	output logic read_valid, // Read answer strobe
	output logic count_gate, // Converter count gate
	output logic carry_flag, // Carry flag for the ALU
	output logic timer_wake_request, // Timer underflow request
	output logic halt_entry_refused, // Halt may not be entered
	output logic [5:0] timer_count // Current timer value
);

	typedef struct packed {
		logic [2:0] clk_sel;
		logic tap_prev;
		logic reload_en;
		logic defer_gate_clear;
		logic gate;
		logic gate_by_timer;
		logic prescale_req;
		logic timer_req;
		logic rfc_req;
		logic prescale_en;
		logic timer_en;
		logic rfc_en;
		logic port_start;
		logic summary;
		logic carry;
		logic overflow;
		logic [3:0] rd_data;
		logic rd_valid;
	} wake_state_t;

	wake_state_t state_reg;
	wake_state_t state_next;

	timer_ctrl_if tif ();

	second_down_timer u_timer (
		.clock(clock),
		.resetn(resetn),
		.tif(tif)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock source selection

	function automatic logic tap_level(input logic [2:0] sel, input logic [15:1] st, input logic fq);
		logic lvl;
		lvl = 1'b0;
		case (sel)
			timer_wake_pkg::SEL_STAGE9: lvl = st[9];
			timer_wake_pkg::SEL_STAGE3: lvl = st[3];
			timer_wake_pkg::SEL_STAGE15: lvl = st[15];
			timer_wake_pkg::SEL_FREQ: lvl = fq;
			timer_wake_pkg::SEL_STAGE5: lvl = st[5];
			timer_wake_pkg::SEL_STAGE7: lvl = st[7];
			timer_wake_pkg::SEL_STAGE11: lvl = st[11];
			default: lvl = st[13];
		endcase
		return lvl;
	endfunction

	logic tap_now;
	logic timer_tick;
	logic is_cmd;

	assign tap_now = tap_level(state_reg.clk_sel, prescale_stage, freq_level);
	// Rising edge of the chosen stage or frequency level is the timer's count enable
	assign timer_tick = tap_now && !state_reg.tap_prev;

	////////////////////////////////////////////////////////////////////////
	// Start flags and status views

	logic prescale_start;
	logic timer_start;
	logic rfc_start;
	logic start_any;
	logic zero_flag;
	logic [3:0] arith_view;
	logic [3:0] summary_view;
	logic [3:0] prescale_view;
	logic [3:0] source_view;
	logic [3:0] overflow_view;

	assign prescale_start = state_reg.prescale_req && state_reg.prescale_en;
	assign timer_start = state_reg.timer_req && state_reg.timer_en;
	assign rfc_start = state_reg.rfc_req && state_reg.rfc_en;
	assign start_any = prescale_start || timer_start || rfc_start;
	assign zero_flag = (acc_nibble == timer_wake_pkg::ACC_ZERO);

	always_comb begin
		arith_view = timer_wake_pkg::STS_RESET;
		arith_view[timer_wake_pkg::CARRY_BIT] = state_reg.carry;
		arith_view[timer_wake_pkg::ZERO_BIT] = zero_flag;
		summary_view = timer_wake_pkg::STS_RESET;
		summary_view[timer_wake_pkg::SUMMARY_BIT] = state_reg.summary;
		prescale_view = timer_wake_pkg::STS_RESET;
		prescale_view[timer_wake_pkg::PRESCALE_START_BIT] = prescale_start;
		prescale_view[timer_wake_pkg::STAGE15_BIT] = prescale_stage[timer_wake_pkg::STAGE_HI];
		source_view = timer_wake_pkg::STS_RESET;
		source_view[timer_wake_pkg::RFC_START_BIT] = rfc_start;
		source_view[timer_wake_pkg::PORT_START_BIT] = state_reg.port_start;
		source_view[timer_wake_pkg::TIMER_START_BIT] = timer_start;
		overflow_view = timer_wake_pkg::STS_RESET;
		overflow_view[timer_wake_pkg::OVERFLOW_BIT] = state_reg.overflow;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	assign is_cmd = cmd_valid;

	always_comb begin
		state_next = state_reg;
		state_next.tap_prev = tap_now;
		state_next.rd_valid = 1'b0;

		// Clears from instructions come first so that same-cycle events win
		if (is_cmd) begin
			case (cmd_op)
				timer_wake_pkg::CMD_SET_FLAG_GROUP_TWO: begin
					if (cmd_arg[timer_wake_pkg::FLAG2_RELOAD_BIT]) begin
						state_next.reload_en = 1'b1;
					end
					if (cmd_arg[timer_wake_pkg::FLAG2_DEFER_BIT]) begin
						state_next.defer_gate_clear = 1'b1;
					end
				end
				timer_wake_pkg::CMD_CLEAR_FLAG_GROUP_TWO: begin
					if (cmd_arg[timer_wake_pkg::FLAG2_RELOAD_BIT]) begin
						state_next.reload_en = 1'b0;
					end
					if (cmd_arg[timer_wake_pkg::FLAG2_DEFER_BIT]) begin
						state_next.defer_gate_clear = 1'b0;
					end
				end
				timer_wake_pkg::CMD_CLEAR_WAKE_REQUEST: begin
					if (cmd_arg[timer_wake_pkg::WAKE_PRESCALE_BIT]) begin
						state_next.prescale_req = 1'b0;
					end
					if (cmd_arg[timer_wake_pkg::WAKE_TIMER_BIT]) begin
						state_next.timer_req = 1'b0;
					end
					if (cmd_arg[timer_wake_pkg::WAKE_RFC_BIT]) begin
						state_next.rfc_req = 1'b0;
					end
				end
				timer_wake_pkg::CMD_SET_WAKE_ENABLES: begin
					state_next.prescale_en = cmd_arg[timer_wake_pkg::WAKE_PRESCALE_BIT];
					state_next.timer_en = cmd_arg[timer_wake_pkg::WAKE_TIMER_BIT];
					state_next.rfc_en = cmd_arg[timer_wake_pkg::WAKE_RFC_BIT];
				end
				timer_wake_pkg::CMD_READ_ARITH_STATUS: begin
					state_next.rd_data = arith_view;
					state_next.rd_valid = 1'b1;
				end
				timer_wake_pkg::CMD_WRITE_ARITH_STATUS: begin
					// Zero flag follows the accumulator, so only the carry loads
					state_next.carry = ram_nibble[timer_wake_pkg::CARRY_BIT];
				end
				timer_wake_pkg::CMD_READ_SUMMARY_STATUS: begin
					state_next.rd_data = summary_view;
					state_next.rd_valid = 1'b1;
				end
				timer_wake_pkg::CMD_READ_PRESCALE_STATUS: begin
					state_next.rd_data = prescale_view;
					state_next.rd_valid = 1'b1;
				end
				timer_wake_pkg::CMD_READ_SOURCE_STATUS: begin
					state_next.rd_data = source_view;
					state_next.rd_valid = 1'b1;
				end
				timer_wake_pkg::CMD_READ_OVERFLOW_STATUS: begin
					state_next.rd_data = overflow_view;
					state_next.rd_valid = 1'b1;
				end
				timer_wake_pkg::CMD_SELECT_PORT_CHANGE: begin
					state_next.port_start = 1'b0;
				end
				timer_wake_pkg::CMD_START_RFC_COUNTER: begin
					state_next.overflow = 1'b0;
					state_next.gate_by_timer = cmd_arg[timer_wake_pkg::RFC_TIMER_GATE_BIT];
					state_next.gate = 1'b0;
				end
				timer_wake_pkg::CMD_LOAD_TIMER: begin
					state_next.clk_sel = cmd_arg[timer_wake_pkg::CLK_SEL_LSB +: timer_wake_pkg::CLK_SEL_W];
					if (state_reg.gate_by_timer) begin
						state_next.gate = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// ALU carry updates unless the status load owns the carry this cycle
		if (carry_update && !(is_cmd && cmd_op == timer_wake_pkg::CMD_WRITE_ARITH_STATUS)) begin
			state_next.carry = carry_value;
		end

		// Hardware events, set wins over any clear above
		if (tif.underflow) begin
			state_next.timer_req = 1'b1;
			if (!state_reg.defer_gate_clear) begin
				state_next.gate = 1'b0;
			end
		end
		if (prescale_overflow) begin
			state_next.prescale_req = 1'b1;
		end
		if (rfc_finish) begin
			state_next.rfc_req = 1'b1;
		end
		if (port_change_release) begin
			state_next.port_start = 1'b1;
		end
		if (rfc_counter_overflow) begin
			state_next.overflow = 1'b1;
		end

		// Summary holds while any timed start flag stands
		state_next.summary = other_halt_release || start_any;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
			state_reg.clk_sel <= timer_wake_pkg::SEL_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer control and outputs

	assign tif.load = is_cmd && (cmd_op == timer_wake_pkg::CMD_LOAD_TIMER);
	assign tif.init = cmd_arg[timer_wake_pkg::CNT_W-1:0];
	assign tif.tick = timer_tick;
	assign tif.reload_en = state_reg.reload_en;

	assign read_nibble = state_reg.rd_data;
	assign read_valid = state_reg.rd_valid;
	assign count_gate = state_reg.gate;
	assign carry_flag = state_reg.carry;
	assign timer_wake_request = state_reg.timer_req;
	assign timer_count = tif.count;
	// Port start flag also blocks halt entry
	assign halt_entry_refused = start_any || state_reg.port_start || state_reg.summary;

endmodule
`default_nettype wire

// ### logic/timer_wake_pkg.sv
// Constants, field positions and command codes for the reload timer and wake status block
`default_nettype none
package timer_wake_pkg;

	// Timer geometry
	localparam int CNT_W = 6;
	localparam logic [5:0] CNT_MAX = 6'h3f;
	localparam logic [5:0] CNT_ZERO = 6'h00;
	localparam int STS_W = 4;
	localparam int ARG_W = 9;
	localparam int CLK_SEL_LSB = 6;
	localparam int CLK_SEL_W = 3;
	localparam int STAGE_LO = 1;
	localparam int STAGE_HI = 15;

	// Clock select codes held in the load operand
	localparam logic [2:0] SEL_STAGE9 = 3'h0;
	localparam logic [2:0] SEL_STAGE3 = 3'h1;
	localparam logic [2:0] SEL_STAGE15 = 3'h2;
	localparam logic [2:0] SEL_FREQ = 3'h3;
	localparam logic [2:0] SEL_STAGE5 = 3'h4;
	localparam logic [2:0] SEL_STAGE7 = 3'h5;
	localparam logic [2:0] SEL_STAGE11 = 3'h6;
	localparam logic [2:0] SEL_STAGE13 = 3'h7;
	localparam logic [2:0] SEL_RESET = SEL_STAGE7;

	// Flag group two operand bits
	localparam int FLAG2_RELOAD_BIT = 0;
	localparam int FLAG2_DEFER_BIT = 1;

	// Wake request clear and wake enable operand bits
	localparam int WAKE_PRESCALE_BIT = 3;
	localparam int WAKE_TIMER_BIT = 4;
	localparam int WAKE_RFC_BIT = 6;

	// Converter start operand: gate driven by the timer
	localparam int RFC_TIMER_GATE_BIT = 4;

	// Status register field positions
	localparam int CARRY_BIT = 3;
	localparam int ZERO_BIT = 2;
	localparam int SUMMARY_BIT = 2;
	localparam int PRESCALE_START_BIT = 3;
	localparam int STAGE15_BIT = 2;
	localparam int RFC_START_BIT = 3;
	localparam int PORT_START_BIT = 2;
	localparam int TIMER_START_BIT = 1;
	localparam int OVERFLOW_BIT = 2;
	localparam logic [3:0] STS_RESET = 4'h0;
	localparam logic [3:0] ACC_ZERO = 4'h0;

	typedef enum logic [3:0] {
		CMD_NONE = 4'b0000,
		CMD_SET_FLAG_GROUP_TWO = 4'b0001,
		CMD_CLEAR_FLAG_GROUP_TWO = 4'b0010,
		CMD_CLEAR_WAKE_REQUEST = 4'b0011,
		CMD_SET_WAKE_ENABLES = 4'b0100,
		CMD_READ_ARITH_STATUS = 4'b0101,
		CMD_WRITE_ARITH_STATUS = 4'b0110,
		CMD_READ_SUMMARY_STATUS = 4'b0111,
		CMD_READ_PRESCALE_STATUS = 4'b1000,
		CMD_READ_SOURCE_STATUS = 4'b1001,
		CMD_READ_OVERFLOW_STATUS = 4'b1010,
		CMD_SELECT_PORT_CHANGE = 4'b1011,
		CMD_START_RFC_COUNTER = 4'b1100,
		CMD_LOAD_TIMER = 4'b1101
	} cmd_op_t;

endpackage
`default_nettype wire

// ### testbench/tb.sv
// Random and directed bench for the reload timer and wake status block
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam timer_wake_pkg::cmd_op_t SRC = timer_wake_pkg::CMD_READ_SOURCE_STATUS;
	localparam timer_wake_pkg::cmd_op_t SUM = timer_wake_pkg::CMD_READ_SUMMARY_STATUS;
	localparam timer_wake_pkg::cmd_op_t LOAD = timer_wake_pkg::CMD_LOAD_TIMER;
	localparam timer_wake_pkg::cmd_op_t CLR = timer_wake_pkg::CMD_CLEAR_WAKE_REQUEST;
	localparam timer_wake_pkg::cmd_op_t ARI = timer_wake_pkg::CMD_READ_ARITH_STATUS;
	localparam timer_wake_pkg::cmd_op_t PRE = timer_wake_pkg::CMD_READ_PRESCALE_STATUS;
	localparam timer_wake_pkg::cmd_op_t FL2 = timer_wake_pkg::CMD_CLEAR_FLAG_GROUP_TWO;
	localparam timer_wake_pkg::cmd_op_t ENA = timer_wake_pkg::CMD_SET_WAKE_ENABLES;
	logic clock, resetn, cmd_valid, carry_update, carry_value, freq_level;
	timer_wake_pkg::cmd_op_t cmd_op;
	logic [8:0] cmd_arg;
	logic [3:0] ram_nibble, acc_nibble, read_nibble;
	logic [15:1] prescale_stage;
	logic [4:0] ev;
	wire prescale_overflow, port_change_release, other_halt_release, rfc_finish, rfc_counter_overflow;
	logic read_valid, count_gate, carry_flag, timer_wake_request, halt_entry_refused;
	logic [5:0] timer_count, init;
	logic [31:0] lfsr;
	int n_errors, check_count;

	assign {prescale_overflow, port_change_release, other_halt_release, rfc_finish, rfc_counter_overflow} = ev;
	timer_reload_wake_status DUT (
		.clock(clock),
		.resetn(resetn),
		.cmd_valid(cmd_valid),
		.cmd_op(cmd_op),
		.cmd_arg(cmd_arg),
		.ram_nibble(ram_nibble),
		.acc_nibble(acc_nibble),
		.carry_update(carry_update),
		.carry_value(carry_value),
		.prescale_stage(prescale_stage),
		.freq_level(freq_level),
		.prescale_overflow(prescale_overflow),
		.port_change_release(port_change_release),
		.other_halt_release(other_halt_release),
		.rfc_finish(rfc_finish),
		.rfc_counter_overflow(rfc_counter_overflow),
		.read_nibble(read_nibble),
		.read_valid(read_valid),
		.count_gate(count_gate),
		.carry_flag(carry_flag),
		.timer_wake_request(timer_wake_request),
		.halt_entry_refused(halt_entry_refused),
		.timer_count(timer_count)
	);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	////////////////////////////////////////
	function automatic logic [31:0] next_rand(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	function automatic logic [3:0] arith_exp(logic c, logic [3:0] a);
		return {c, a == 4'h0, 2'b00};
	endfunction

	task automatic stop_test;
		$display("checks=%0d errors=%0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check_val(logic [7:0] got, logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Result is sampled 1 ns after the taking edge, while the one-cycle read strobe stands
	task automatic issue(timer_wake_pkg::cmd_op_t op, logic [8:0] arg);
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_arg <= arg;
		@(posedge clock);
		cmd_valid <= 1'b0;
		#1;
	endtask

	task automatic read_reg(timer_wake_pkg::cmd_op_t op, logic [3:0] exp);
		issue(op, 9'h000);
		check_val({3'h0, read_valid, read_nibble}, {4'h1, exp});
	endtask

	// One rising edge on stage 3 and on the frequency level, with room for the late wake flag
	task automatic tick;
		@(posedge clock);
		prescale_stage[3] <= 1'b1;
		freq_level <= 1'b1;
		repeat (2) @(posedge clock);
		prescale_stage[3] <= 1'b0;
		freq_level <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
	endtask

	task automatic count_down(logic [5:0] from);
		for (int i = from; i > 0; i--) begin
			tick();
			check_val({2'b00, timer_count}, 8'(i - 1));
		end
	endtask

	task automatic pulse(logic [4:0] m);
		@(posedge clock);
		ev <= m;
		@(posedge clock);
		ev <= 5'h00;
		@(posedge clock);
		#1;
	endtask
	////////////////////////////////////////
	initial begin
		#1000000;
		n_errors++;
		stop_test();
	end

	initial begin
		resetn = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = timer_wake_pkg::CMD_NONE;
		cmd_arg = 9'h000;
		ram_nibble = 4'h0;
		acc_nibble = 4'h0;
		carry_update = 1'b0;
		carry_value = 1'b0;
		prescale_stage = 15'h0000;
		freq_level = 1'b0;
		ev = 5'h00;
		lfsr = 32'h0e442097;
		n_errors = 0;
		check_count = 0;
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		read_reg(ARI, 4'h4);
		read_reg(SUM, 4'h0);
		read_reg(PRE, 4'h0);
		read_reg(SRC, 4'h0);
		read_reg(timer_wake_pkg::CMD_READ_OVERFLOW_STATUS, 4'h0);
		check_val({count_gate, 1'b0, timer_count}, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			lfsr = next_rand(lfsr);
			if (i == 0) lfsr[3:0] = 4'h0;
			@(posedge clock);
			acc_nibble <= lfsr[3:0];
			prescale_stage[15] <= lfsr[5];
			carry_update <= 1'b1;
			carry_value <= lfsr[4];
			@(posedge clock);
			carry_update <= 1'b0;
			read_reg(ARI, arith_exp(lfsr[4], lfsr[3:0]));
			read_reg(PRE, {1'b0, lfsr[5], 2'b00});
			@(posedge clock);
			ram_nibble <= lfsr[11:8];
			issue(timer_wake_pkg::CMD_WRITE_ARITH_STATUS, 9'h000);
			check_val({7'h00, carry_flag}, {7'h00, lfsr[11]});
			read_reg(ARI, arith_exp(lfsr[11], lfsr[3:0]));
		end
		$display("test status done");
		lfsr = next_rand(lfsr);
		init = 6'h01 + {3'h0, lfsr[2:0]};
		issue(LOAD, {timer_wake_pkg::SEL_STAGE3, init});
		count_down(init);
		tick();
		check_val({timer_wake_request, 1'b0, timer_count}, 8'hbf);
		tick();
		check_val({2'b00, timer_count}, 8'h3f);
		issue(CLR, 9'h010);
		check_val({7'h00, timer_wake_request}, 8'h00);
		issue(timer_wake_pkg::CMD_SET_FLAG_GROUP_TWO, 9'h001);
		issue(LOAD, {timer_wake_pkg::SEL_STAGE3, init});
		count_down(init);
		tick();
		check_val({timer_wake_request, 1'b0, timer_count}, {2'b10, init});
		count_down(init);
		issue(FL2, 9'h001);
		tick();
		check_val({2'b00, timer_count}, 8'h3f);
		issue(CLR, 9'h010);
		issue(LOAD, {timer_wake_pkg::SEL_FREQ, 6'h02});
		count_down(6'h02);
		issue(LOAD, {timer_wake_pkg::SEL_STAGE9, 6'h02});
		tick();
		check_val({2'b00, timer_count}, 8'h02);
		$display("test timer done");
		issue(timer_wake_pkg::CMD_START_RFC_COUNTER, 9'h010);
		issue(timer_wake_pkg::CMD_SET_FLAG_GROUP_TWO, 9'h003);
		issue(LOAD, {timer_wake_pkg::SEL_STAGE3, 6'h01});
		check_val({7'h00, count_gate}, 8'h01);
		tick();
		tick();
		check_val({count_gate, timer_wake_request, timer_count}, 8'hc1);
		issue(FL2, 9'h002);
		tick();
		tick();
		check_val({count_gate, 1'b0, timer_count}, 8'h01);
		issue(FL2, 9'h001);
		issue(CLR, 9'h010);
		$display("test gate done");
		issue(ENA, 9'h058);
		issue(LOAD, {timer_wake_pkg::SEL_STAGE3, 6'h00});
		tick();
		read_reg(SRC, 4'h2);
		read_reg(SUM, 4'h4);
		check_val({7'h00, halt_entry_refused}, 8'h01);
		issue(CLR, 9'h010);
		read_reg(SRC, 4'h0);
		read_reg(SUM, 4'h0);
		pulse(5'h10);
		read_reg(PRE, {1'b1, prescale_stage[15], 2'b00});
		issue(ENA, 9'h050);
		read_reg(PRE, {1'b0, prescale_stage[15], 2'b00});
		pulse(5'h02);
		read_reg(SRC, 4'h8);
		issue(ENA, 9'h000);
		read_reg(SRC, 4'h0);
		pulse(5'h08);
		read_reg(SRC, 4'h4);
		read_reg(SUM, 4'h0);
		check_val({7'h00, halt_entry_refused}, 8'h01);
		issue(timer_wake_pkg::CMD_SELECT_PORT_CHANGE, 9'h000);
		read_reg(SRC, 4'h0);
		@(posedge clock);
		ev <= 5'h04;
		read_reg(SUM, 4'h4);
		check_val({7'h00, halt_entry_refused}, 8'h01);
		@(posedge clock);
		ev <= 5'h00;
		read_reg(SUM, 4'h0);
		pulse(5'h01);
		read_reg(timer_wake_pkg::CMD_READ_OVERFLOW_STATUS, 4'h4);
		issue(timer_wake_pkg::CMD_START_RFC_COUNTER, 9'h000);
		read_reg(timer_wake_pkg::CMD_READ_OVERFLOW_STATUS, 4'h0);
		$display("test wake done");
		stop_test();
	end
endmodule
`default_nettype wire

// ### testbench/timer_wake_assertions.sv
// Port checks for the reload timer and wake status block
`timescale 1ns/1ps
`default_nettype none
module timer_wake_assertions (
	input wire logic clock, // Core clock
	input wire logic resetn, // Reset, active low
	input wire logic cmd_valid, // Strobe
	input wire timer_wake_pkg::cmd_op_t cmd_op, // Code
	input wire logic [8:0] cmd_arg, // Operand
	input wire logic [3:0] ram_nibble, // RAM data
	input wire logic [3:0] acc_nibble, // Accumulator
	input wire logic carry_update, // ALU write
	input wire logic carry_value, // ALU carry
	input wire logic [15:1] prescale_stage, // Stages
	input wire logic rfc_counter_overflow, // Overflow
	input wire logic [3:0] read_nibble, // Read data
	input wire logic read_valid, // Read strobe
	input wire logic count_gate, // Gate
	input wire logic carry_flag, // Carry
	input wire logic timer_wake_request, // Wake
	input wire logic [5:0] timer_count // Count
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!resetn);
	////////////////////////////////////////
	idle_read_a: assert property (!cmd_valid |=> !read_valid)
		else $error("read strobe without instruction");
	src_format_a: assert property (cmd_valid && cmd_op == timer_wake_pkg::CMD_READ_SOURCE_STATUS
		|=> read_valid && !read_nibble[0]) else $error("source status bit 0 set");
	zero_flag_a: assert property (cmd_valid && cmd_op == timer_wake_pkg::CMD_READ_ARITH_STATUS
		|=> read_nibble[2:0] == {$past(acc_nibble) == 4'h0, 2'b00}) else $error("zero flag wrong");
	stage_read_a: assert property (cmd_valid && cmd_op == timer_wake_pkg::CMD_READ_PRESCALE_STATUS
		|=> read_nibble[2:0] == {$past(prescale_stage[15]), 2'b00}) else $error("stage bit wrong");
	carry_load_a: assert property (cmd_valid && cmd_op == timer_wake_pkg::CMD_WRITE_ARITH_STATUS
		&& !carry_update |=> carry_flag == $past(ram_nibble[3])) else $error("carry not loaded");
	carry_alu_a: assert property (carry_update && !cmd_valid
		|=> carry_flag == $past(carry_value)) else $error("carry not updated");
	ovf_read_a: assert property (rfc_counter_overflow
		##1 (!(cmd_valid && cmd_op == timer_wake_pkg::CMD_START_RFC_COUNTER)) [*2]
		##1 (cmd_valid && cmd_op == timer_wake_pkg::CMD_READ_OVERFLOW_STATUS) |=> read_nibble == 4'h4)
		else $error("overflow flag missing");
	timer_load_a: assert property (cmd_valid && cmd_op == timer_wake_pkg::CMD_LOAD_TIMER
		|=> timer_count == $past(cmd_arg[5:0])) else $error("load value wrong");
	count_step_a: assert property (!$past(cmd_valid) && $changed(timer_count)
		&& $past(timer_count) != 6'h00 |-> timer_count == $past(timer_count) - 6'h01)
		else $error("count step wrong");
	gate_close_a: assert property ($fell(count_gate) && !$past(cmd_valid) |-> timer_wake_request)
		else $error("gate closed without underflow");
	wake_hold_a: assert property (timer_wake_request && !(cmd_valid && cmd_arg[4]
		&& cmd_op == timer_wake_pkg::CMD_CLEAR_WAKE_REQUEST) |=> timer_wake_request)
		else $error("wake request lost");
endmodule
bind timer_reload_wake_status timer_wake_assertions checker_inst (
	.clock(clock), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg(cmd_arg),
	.ram_nibble(ram_nibble), .acc_nibble(acc_nibble), .carry_update(carry_update),
	.carry_value(carry_value), .prescale_stage(prescale_stage), .rfc_counter_overflow(rfc_counter_overflow),
	.read_nibble(read_nibble), .read_valid(read_valid), .count_gate(count_gate), .carry_flag(carry_flag),
	.timer_wake_request(timer_wake_request), .timer_count(timer_count)
);
`default_nettype wire
